/* design/bmu_top.sv */
`timescale 1ns/1ps
// multiply datapath driven by the core's four-phase cycle
module bmu_top
(
    input  wire logic                sys_clk_in,       // 200 MHz core clock
    input  wire logic                rst_n_in,         // async active-low reset
    input  wire logic                phase_en_in,      // one-cycle phase advance pulse
    input  wire logic [1:0]          phase_in,         // current phase, 0..3
    input  wire logic [15:0]         opcode_in,        // instruction word
    input  wire logic [7:0]          working_reg_in,   // working register value
    input  wire logic [3:0]          bank_ptr_in,      // bank select pointer
    output bmu_pkg::bmu_fread_t      fread_out,        // file read request
    input  wire logic [7:0]          fdata_in,         // file read data
    input  wire logic                product_high_we_in,      // software write product-high
    input  wire logic                product_low_we_in,      // software write product-low
    input  wire logic [7:0]          wdata_in,         // software write data
    output logic      [7:0]          product_high_out, // product-high register
    output logic      [7:0]          product_low_out,  // product-low register
    output logic                     busy_out,         // multiply in progress
    output logic                     done_out,         // product written pulse
    output logic                     flags_we_out,     // status flag write strobe
    output logic                     working_register_we_out       // working register write strobe
);
    bmu_pkg::bmu_state_t st_reg;   // registered state
    bmu_pkg::bmu_state_t st_next;  // next state
    logic [15:0]         prod;     // multiplier output
    logic                is_lit;   // literal opcode seen
    logic                is_file;  // file opcode seen
    logic [11:0]         faddr;    // resolved file address

    // the product arithmetic
    bmu_mult8 u_mult
    (
        .a_in  (working_reg_in),
        .b_in  (st_reg.operand),
        .p_out (prod)
    );

    // opcode decode
    assign is_lit  = (opcode_in[15:8] == bmu_pkg::BMU_OPC_LIT);
    assign is_file = (opcode_in[15:9] == bmu_pkg::BMU_OPC_FILE);

    // bank resolution of the file address
    always_comb
    begin
        if (opcode_in[bmu_pkg::BMU_ACCESS_BIT])
        begin
            faddr = {bank_ptr_in, opcode_in[7:0]};
        end
        else if (opcode_in[7:0] < bmu_pkg::BMU_ACC_SPLIT)
        begin
            faddr = {4'h0, opcode_in[7:0]};
        end
        else
        begin
            faddr = {bmu_pkg::BMU_ACC_HIGH_BANK, opcode_in[7:0]};
        end
    end

    // read request only in phase two of a file multiply
    always_comb
    begin
        fread_out.rd_en = (st_reg.op == bmu_pkg::BMU_OP_FILE) && phase_en_in
                          && (phase_in == bmu_pkg::BMU_PH_READ);
        fread_out.addr  = faddr;
    end

    // next-state: decode, read, process, write per phase
    always_comb
    begin
        st_next      = st_reg;
        st_next.done = 1'b0;
        if (phase_en_in)
        begin
            case (phase_in)
                bmu_pkg::BMU_PH_DECODE:
                begin
                    // decode
                    if (is_lit)
                    begin
                        st_next.op = bmu_pkg::BMU_OP_LIT;
                    end
                    else if (is_file)
                    begin
                        st_next.op = bmu_pkg::BMU_OP_FILE;
                    end
                    else
                    begin
                        st_next.op = bmu_pkg::BMU_OP_NONE;
                    end
                end
                bmu_pkg::BMU_PH_READ:
                begin
                    // fetch operand
                    if (st_reg.op == bmu_pkg::BMU_OP_LIT)
                    begin
                        st_next.operand = opcode_in[7:0];
                    end
                    else if (st_reg.op == bmu_pkg::BMU_OP_FILE)
                    begin
                        st_next.operand = fdata_in;
                    end
                end
                bmu_pkg::BMU_PH_PROCESS:
                begin
                    // compute
                    st_next.product = prod;
                end
                bmu_pkg::BMU_PH_WRITE:
                begin
                    // write both product bytes
                    if (st_reg.op != bmu_pkg::BMU_OP_NONE)
                    begin
                        st_next.prod_high = st_reg.product[15:8];
                        st_next.prod_low  = st_reg.product[7:0];
                        st_next.done      = 1'b1;
                    end
                    st_next.op = bmu_pkg::BMU_OP_NONE;
                end
                default:
                begin
                    st_next.op = bmu_pkg::BMU_OP_NONE;
                end
            endcase
        end
        // software access when no product write is taking place
        if (!st_next.done)
        begin
            if (product_high_we_in)
            begin
                st_next.prod_high = wdata_in;
            end
            if (product_low_we_in)
            begin
                st_next.prod_low = wdata_in;
            end
        end
    end

    // state register
    always_ff @(posedge sys_clk_in or negedge rst_n_in)
    begin
        if (!rst_n_in)
        begin
            st_reg <= '{op: bmu_pkg::BMU_OP_NONE, operand: 8'h00, product: 16'h0000,
                        prod_high: bmu_pkg::BMU_PROD_RST,
                        prod_low: bmu_pkg::BMU_PROD_RST, done: 1'b0};
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // outputs
    assign product_high_out = st_reg.prod_high;
    assign product_low_out  = st_reg.prod_low;
    assign busy_out         = (st_reg.op != bmu_pkg::BMU_OP_NONE);
    assign done_out         = st_reg.done;
    assign flags_we_out     = 1'b0;
    assign working_register_we_out      = 1'b0;

    // operand capture and product write sequences
    sequence s_lit_read;
        phase_en_in && phase_in == bmu_pkg::BMU_PH_READ && st_reg.op == bmu_pkg::BMU_OP_LIT;
    endsequence
    sequence s_write;
        phase_en_in && phase_in == bmu_pkg::BMU_PH_WRITE && st_reg.op != bmu_pkg::BMU_OP_NONE;
    endsequence

    AST_LIT_DECODE: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        phase_en_in && phase_in == bmu_pkg::BMU_PH_DECODE && is_lit
        |=> st_reg.op == bmu_pkg::BMU_OP_LIT)
        else $error("literal opcode not decoded");
    AST_LIT_OPERAND: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        s_lit_read |=> st_reg.operand == $past(opcode_in[7:0]))
        else $error("literal operand not captured");
    AST_PROD_WRITE: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        s_write |=> {product_high_out, product_low_out} == $past(st_reg.product) && done_out)
        else $error("product pair not written");
    AST_NO_FLAGS: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        !flags_we_out)
        else $error("status flags written");
    AST_NO_WORKING_REGISTER: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        !working_register_we_out)
        else $error("working register written");
    AST_FILE_READ: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        fread_out.rd_en |=> st_reg.operand == $past(fdata_in))
        else $error("file operand not captured");
    AST_ACCESS_WIN: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        fread_out.rd_en && !opcode_in[8] && opcode_in[7:0] < 8'h80
        |-> fread_out.addr[11:8] == 4'h0)
        else $error("access window not used");
    AST_BANKED: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        fread_out.rd_en && opcode_in[8] |-> fread_out.addr[11:8] == bank_ptr_in)
        else $error("bank pointer not used");
    AST_PHASE4: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        done_out |-> $past(phase_in) == bmu_pkg::BMU_PH_WRITE && $past(phase_en_in))
        else $error("product written outside phase four");
    AST_SW_WRITE: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        product_low_we_in && !st_next.done |=> product_low_out == $past(wdata_in))
        else $error("software write to product-low lost");
    AST_NO_OVF: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        phase_en_in && phase_in == bmu_pkg::BMU_PH_PROCESS
        |=> st_reg.product == 16'($past(working_reg_in)) * 16'($past(st_reg.operand)))
        else $error("product wrong");
    // upper window half maps to the fixed high bank
    AST_ACCESS_HIGH: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        fread_out.rd_en && !opcode_in[bmu_pkg::BMU_ACCESS_BIT]
        && opcode_in[7:0] >= bmu_pkg::BMU_ACC_SPLIT
        |-> fread_out.addr[11:8] == bmu_pkg::BMU_ACC_HIGH_BANK)
        else $error("upper access window not used");
    // offset byte passes straight through the bank resolution
    AST_FILE_OFFSET: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        fread_out.rd_en |-> fread_out.addr[7:0] == opcode_in[7:0])
        else $error("file offset altered");
    // done stands exactly one cycle and leaves the unit idle
    AST_DONE_PULSE: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        done_out |-> !busy_out ##1 !done_out)
        else $error("done not a single idle pulse");
    // product-high keeps its value unless a product or software write lands
    AST_PRODUCT_HIGH_HOLD: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
        !product_high_we_in && !(phase_en_in && phase_in == bmu_pkg::BMU_PH_WRITE
        && st_reg.op != bmu_pkg::BMU_OP_NONE) |=> $stable(product_high_out))
        else $error("product-high changed without a write");
endmodule

/* design/bmu_pkg.sv */
// Overview of operation
// - opcode high 0x0d multiplies working register by literal
// - literal product written high and low bytes
// - literal multiply leaves working register unchanged
// - no status flag changes on either multiply
// - file multiply uses byte at address 0..255
// - file multiply leaves working and file registers
// - access bit zero selects fast-access window
// - access bit one uses bank select pointer
// - one instruction cycle, product written in phase four
// - no overflow or carry indication ever raised
package bmu_pkg;
    localparam logic [7:0] BMU_OPC_LIT       = 8'h0d;  // literal multiply high byte
    localparam logic [6:0] BMU_OPC_FILE      = 7'h01;  // file multiply upper seven bits
    localparam int         BMU_ACCESS_BIT    = 8;      // access-select bit position
    localparam logic [7:0] BMU_ACC_SPLIT     = 8'h80;  // window low half / high half split
    localparam logic [3:0] BMU_ACC_HIGH_BANK = 4'hf;   // bank of upper window half
    localparam logic [1:0] BMU_PH_DECODE     = 2'h0;   // phase one
    localparam logic [1:0] BMU_PH_READ       = 2'h1;   // phase two
    localparam logic [1:0] BMU_PH_PROCESS    = 2'h2;   // phase three
    localparam logic [1:0] BMU_PH_WRITE      = 2'h3;   // phase four
    localparam logic [7:0] BMU_PROD_RST      = 8'h00;  // product reset value

    // instruction kinds
    typedef enum logic [1:0] {BMU_OP_NONE, BMU_OP_LIT, BMU_OP_FILE} bmu_op_t;

    // data-memory read request toward the register file
    typedef struct packed {
        logic        rd_en;   // read strobe in phase two
        logic [11:0] addr;    // full bank:offset address
    } bmu_fread_t;

    // state of the unit
    typedef struct packed {
        bmu_op_t     op;         // decoded instruction
        logic [7:0]  operand;    // literal or file byte
        logic [15:0] product;    // computed product
        logic [7:0]  prod_high;  // product-high register
        logic [7:0]  prod_low;   // product-low register
        logic        done;       // product written this cycle
    } bmu_state_t;
endpackage

/* design/bmu_mult8.sv */
`timescale 1ns/1ps
// unsigned 8x8 multiplier; full width so no overflow exists
module bmu_mult8
(
    input  wire logic [7:0]  a_in,    // first factor
    input  wire logic [7:0]  b_in,    // second factor
    output logic      [15:0] p_out    // full product
);
    // zero-extend to 16 bits before multiplying
    assign p_out = {8'h00, a_in} * {8'h00, b_in};
endmodule

/* bench/bmu_regfile_model.sv */
`timescale 1ns/1ps
// stand-in for the data register file: read only, answers in the same cycle
module bmu_regfile_model
(
    input  wire logic           sys_clk_in, // core clock
    input  bmu_pkg::bmu_fread_t fread_in,   // read request from the unit
    output logic [7:0]          fdata_out   // read data back to the unit
);
    logic [7:0] last_reg = 8'h5a; // byte handed out last cycle

    // bytes follow from the address; nothing writes them, so files stay intact
    always_comb
    begin
        if (fread_in.rd_en)
            fdata_out = fread_in.addr[7:0] ^ {fread_in.addr[11:8], 4'h9};
        else
            fdata_out = ~last_reg; // idle bus never repeats the last byte
    end

    // remember the driven byte so the idle value keeps changing
    always_ff @(posedge sys_clk_in)
        last_reg <= fdata_out;
endmodule

/* bench/tb_byte_multiply_unit.sv */
`timescale 1ns/1ps
// random and corner multiplies through the four phases, checked at the ports
module tb_byte_multiply_unit;
    logic                sys_clk_in = 0, rst_n_in = 0, phase_en_in = 0;
    logic                product_high_we_in = 0, product_low_we_in = 0;
    logic [1:0]          phase_in = 2'h0;
    logic [15:0]         opcode_in = 16'h0000, op;
    logic [7:0]          working_reg_in = 8'h00, wdata_in = 8'h00, fdata_in, ph, pl;
    logic [3:0]          bank_ptr_in = 4'h0;
    logic [31:0]         rnd;
    bmu_pkg::bmu_fread_t fread_out;
    logic [7:0]          product_high_out, product_low_out;
    logic                busy_out, done_out, flags_we_out, working_register_we_out;
    int                  tests_run = 0, failures = 0, cycles = 0;

    always #2.5 sys_clk_in = ~sys_clk_in; // 200 MHz

    bmu_top u_bmu_top (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
        .phase_en_in(phase_en_in), .phase_in(phase_in), .opcode_in(opcode_in),
        .working_reg_in(working_reg_in), .bank_ptr_in(bank_ptr_in), .fread_out(fread_out),
        .fdata_in(fdata_in), .product_high_we_in(product_high_we_in), .product_low_we_in(product_low_we_in),
        .wdata_in(wdata_in), .product_high_out(product_high_out),
        .product_low_out(product_low_out), .busy_out(busy_out), .done_out(done_out),
        .flags_we_out(flags_we_out), .working_register_we_out(working_register_we_out));
    bmu_regfile_model u_bmu_regfile_model (.sys_clk_in(sys_clk_in), .fread_in(fread_out),
        .fdata_out(fdata_in));

    // compare one value and count it
    task chk(string nm, logic [15:0] e, logic [15:0] g);
        tests_run++;
        if (g !== e)
        begin
            $display("Error %s expected %h seen %h", nm, e, g);
            failures++;
        end
    endtask

    // verdict and end of run
    task close_out;
        if (failures == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // one instruction through phases 0..3; clash adds a product-high write in phase 3
    task run_op(logic [15:0] o, logic [7:0] w, logic [3:0] b, logic clash);
        logic        mul;
        logic [11:0] a;
        logic [15:0] e;
        mul = (o[15:8] == 8'h0d) || (o[15:9] == 7'h01);
        a = o[8] ? {b, o[7:0]} : {(o[7] ? 4'hf : 4'h0), o[7:0]};
        e = (o[15:9] == 7'h01) ? 16'(a[7:0] ^ {a[11:8], 4'h9}) : 16'(o[7:0]);
        e = mul ? 16'(w) * e : {(clash ? ~w : ph), pl};
        for (int p = 0; p < 4; p++)
        begin
            @(negedge sys_clk_in);
            phase_en_in = 1;
            phase_in = p[1:0];
            opcode_in = o;
            working_reg_in = w;
            bank_ptr_in = b;
            product_high_we_in = clash && p == 3;
            wdata_in = ~w;
            #1;
            if (p == 1 && o[15:9] == 7'h01)
                chk("read address", {4'h1, a}, {3'h0, fread_out});
            if (p == 1 && o[15:9] != 7'h01)
                chk("read strobe", 16'h0, 16'(fread_out.rd_en));
            if (p == 2)
                chk("busy", 16'(mul), 16'(busy_out));
        end
        @(negedge sys_clk_in);
        phase_en_in = 0;
        product_high_we_in = 0;
        chk("product", e, {product_high_out, product_low_out});
        chk("done", 16'(mul), 16'(done_out));
        chk("strobes", 16'h0, {14'h0, flags_we_out, working_register_we_out});
        {ph, pl} = e;
    endtask

    // software write of one product byte, then read back
    task sw_write(logic h, logic [7:0] d);
        @(negedge sys_clk_in);
        product_high_we_in = h;
        product_low_we_in = !h;
        wdata_in = d;
        @(negedge sys_clk_in);
        product_high_we_in = 0;
        product_low_we_in = 0;
        if (h)
            ph = d;
        else
            pl = d;
        chk("software write", {ph, pl}, {product_high_out, product_low_out});
    endtask

    // hang guard
    always @(posedge sys_clk_in)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            failures++;
            close_out;
        end
    end

    // corner cases first, then random traffic
    initial
    begin
        ph = 8'h00;
        pl = 8'h00;
        rnd = $urandom(68);
        repeat (20) @(negedge sys_clk_in);
        chk("reset", 16'h0000, {product_high_out, product_low_out});
        rst_n_in = 1;
        run_op(16'h0dc4, 8'he2, 4'h0, 0);
        run_op(16'h0d00, 8'h7f, 4'h0, 0);
        run_op(16'h0dff, 8'hff, 4'h0, 0);
        run_op(16'h0210, 8'h33, 4'h5, 0);
        run_op(16'h0290, 8'h44, 4'h5, 0);
        run_op(16'h0390, 8'h55, 4'h5, 0);
        run_op(16'h0e55, 8'h66, 4'h5, 1);
        sw_write(1, 8'h3c);
        sw_write(0, 8'hc3);
        // cut a literal multiply after decode with a mid-run reset
        @(negedge sys_clk_in);
        phase_en_in = 1;
        phase_in = 2'h0;
        opcode_in = 16'h0d55;
        @(negedge sys_clk_in);
        phase_en_in = 0;
        rst_n_in = 0;
        #1;
        chk("reset state", 16'h0000, {product_high_out, product_low_out});
        chk("reset busy", 16'h0, {14'h0, busy_out, done_out});
        @(negedge sys_clk_in);
        rst_n_in = 1;
        ph = 8'h00;
        pl = 8'h00;
        run_op(16'h0d12, 8'h34, 4'h0, 1);
        repeat (300)
        begin
            rnd = $urandom;
            op = rnd[1] ? {7'h01, rnd[10:2]} : {8'h0d, rnd[9:2]};
            op = (rnd[1:0] == 2'h3) ? rnd[27:12] : op;
            run_op(op, 8'($urandom), 4'($urandom), rnd[30]);
            if (rnd[31])
                sw_write(rnd[29], rnd[23:16]);
        end
        close_out;
    end
endmodule
